// ===== spi_baud_gen.sv
module spi_baud_gen
   import spi_pins_pkg::*;
#(
   parameter int CodeW = CODE_W,
   parameter int HalfW = 7
) (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             run,
   input  wire logic [CodeW-1:0] prescaleCode,
   input  wire logic [CodeW-1:0] rateDivideCode,
   output logic                  edgeTick,
   output logic                  bitTick
);

   // half of the power-of-two divider, minus one: 2^code - 1
   function automatic logic [HalfW-1:0] halfLimit(
      input logic [CodeW-1:0] code
   );
      logic [HalfW:0] one;
      one = {{HalfW{1'b0}}, 1'b1};
      halfLimit = HalfW'((one << code) - one);
   endfunction : halfLimit

   logic [CodeW-1:0] preCnt_q;
   logic [HalfW-1:0] halfCnt_q;
   logic             phase_q;
   logic             edgeTick_q;
   logic             bitTick_q;

   wire logic preWrap  = preCnt_q >= prescaleCode;
   wire logic halfWrap = preWrap && (halfCnt_q >= halfLimit(rateDivideCode));

   // prescaler: bus clock divided by code plus one [RULE14] [RULE15]
   // compares use >= so a smaller code written mid-count cannot overrun
   always_ff @(posedge core_clk) begin
      if (reset || !run) begin
         preCnt_q <= '0;
      end else if (preWrap) begin
         preCnt_q <= '0;
      end else begin
         preCnt_q <= CodeW'(preCnt_q + 1'b1);
      end
   end

   // divider: two halves of 2^code prescaler ticks each [RULE16] [RULE17]
   always_ff @(posedge core_clk) begin
      if (reset || !run) begin
         halfCnt_q <= '0;
         phase_q   <= 1'b0;
      end else if (halfWrap) begin
         halfCnt_q <= '0;
         phase_q   <= !phase_q;
      end else if (preWrap) begin
         halfCnt_q <= HalfW'(halfCnt_q + 1'b1);
      end
   end

   // registered pulses; one bit per prescale*rate bus cycles
   always_ff @(posedge core_clk) begin
      if (reset || !run) begin
         edgeTick_q <= 1'b0;
         bitTick_q  <= 1'b0;
      end else begin
         edgeTick_q <= halfWrap;
         bitTick_q  <= halfWrap && phase_q; // [RULE16]
      end
   end

   assign edgeTick = edgeTick_q;
   assign bitTick  = bitTick_q;

endmodule : spi_baud_gen

// ===== spi_far_peer.sv
module spi_far_peer (
   input  wire logic ssOut,
   input  wire logic select_output_enable,
   input  wire logic mosiOut,
   input  wire logic mosiOe,
   input  wire logic misoOut,
   input  wire logic misoOe,
   input  wire logic ssLow,
   input  wire logic drvMosi,
   input  wire logic drvMiso,
   output logic      ssIn,
   output logic      mosiIn,
   output logic      misoIn
);
   timeunit 1ns;
   timeprecision 1ns;

   // pull-ups: a released line reads high; the peer only pulls low,
   // contention shows as unknown so a double driver cannot hide
   assign ssIn   = select_output_enable ? (ssLow ? 1'bx : ssOut) : !ssLow;
   assign mosiIn = mosiOe ? (drvMosi ? 1'bx : mosiOut) : !drvMosi;
   assign misoIn = misoOe ? (drvMiso ? 1'bx : misoOut) : !drvMiso;
endmodule : spi_far_peer

// ===== spi_pin_chk.sv
module spi_pin_chk
   import spi_pins_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic irq,
   input wire logic modeFaultFlag,
   input wire logic ssPortFree,
   input wire logic slaveSelected,
   input wire logic misoPortFree,
   input wire logic ssOut,
   input wire logic select_output_enable,
   input wire logic xferActive,
   input wire logic mosiOe,
   input wire logic misoOe,
   input wire logic waitMode,
   input wire logic clocksRun,
   input wire logic sckEdgeTick,
   input wire logic bitTick
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // enables are registered, so ownership is judged one edge late
   ss_free_a: assert property (
      ssPortFree && $past(ssPortFree) |-> !select_output_enable)
      else $error("select pin driven while left to port logic");
   slave_ss_a: assert property (
      slaveSelected && $past(slaveSelected) |-> !select_output_enable)
      else $error("select pin driven in slave mode");
   auto_ss_a: assert property (
      select_output_enable && $past(select_output_enable) |-> ssOut == !$past(xferActive))
      else $error("auto select does not follow transfer");
   miso_free_a: assert property (
      misoPortFree && $past(misoPortFree) |-> !misoOe)
      else $error("master-in pin driven in single-wire master");
   fault_cause_a: assert property (
      $rose(modeFaultFlag) |-> !ssPortFree && !slaveSelected && !select_output_enable)
      else $error("mode fault raised outside fault-input mode");
   irq_cause_a: assert property (irq |-> modeFaultFlag)
      else $error("interrupt without mode fault");
   wait_stop_a: assert property (!clocksRun |-> waitMode)
      else $error("clocks stopped outside wait mode");
   stop_tick_a: assert property (
      !clocksRun && !$past(clocksRun) && !$past(clocksRun, 2)
      |-> !bitTick && !sckEdgeTick)
      else $error("ticks while clocks stopped");
   tick_gap_a: assert property (bitTick |=> !bitTick)
      else $error("bit period below two cycles");
   reset_quiet_a: assert property (
      $fell(reset) |-> !select_output_enable && !mosiOe && !misoOe && !irq)
      else $error("drivers active after reset");

   // main scenarios reached
   cover property (modeFaultFlag && irq);
   cover property (select_output_enable && !ssOut);
   cover property (misoPortFree && mosiOe);
endmodule : spi_pin_chk

// ===== spi_pin_control.sv
// Summary of operation
// [RULE1] control-two bits 7,6,5,2 read zero; writes there are ignored
// [RULE2] slave mode: fault enable ignored, select pin is low-true input
// [RULE3] master, fault enable off: select pin released to port logic
// [RULE4] master, fault enable on: select pin owned by the interface
// [RULE5] select-output enable 0 means fault input, 1 means auto output
// [RULE6] master with fault input seeing select low sets mode fault
// [RULE7] single-wire off: separate data input and output pins
// [RULE8] single-wire on: master uses master-out pin, slave master-in
// [RULE9] single-wire master leaves master-in pin to port logic
// [RULE10] single-wire output enable: 0 receives, 1 drives the pin
// [RULE11] single-wire off: output enable bit has no effect
// [RULE12] wait-stop bit halts interface clocks during wait mode
// [RULE13] baud register readable and writable at any time
// [RULE14] prescaler input is bus clock, output feeds rate divider
// [RULE15] prescale code bits 6:4 divide by code plus one
// [RULE16] rate code bits 2:0 divide by two to the code plus one
// [RULE17] bit rate is bus clock over prescale times rate divisor
// [RULE18] implemented bits of both registers reset to zero
module spi_pin_control
   import spi_pins_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              reset,
   // apb slave
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_DW-1:0] pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [APB_DW-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   irq,
   // core side
   input  wire logic              waitMode,
   input  wire logic              xferActive,
   input  wire logic              shiftTxBit,
   output logic                   shiftRxBit,
   output logic                   clocksRun,
   output logic                   sckEdgeTick,
   output logic                   bitTick,
   output logic                   modeFaultFlag,
   output logic                   slaveSelected,
   output logic                   ssPortFree,
   output logic                   misoPortFree,
   // pins
   input  wire logic              ssIn,
   output logic                   ssOut,
   output logic                   select_output_enable,
   input  wire logic              mosiIn,
   output logic                   mosiOut,
   output logic                   mosiOe,
   input  wire logic              misoIn,
   output logic                   misoOut,
   output logic                   misoOe
);

   localparam int NPIN   = 3;
   localparam int PIN_SS = 0;
   localparam int PIN_MO = 1;
   localparam int PIN_MI = 2;

   // register state
   // cfg keeps the mode bits that control one would otherwise hold
   ctl2_t            ctl2_q;
   ctl2_t            ctl2_d;
   baud_t            baud_q;
   baud_t            baud_d;
   logic             master_q;
   logic             master_d;
   logic             select_output_enable_q;
   logic             select_output_enable_d;
   logic             faultStat_q;
   logic             faultStat_d;
   logic             faultMask_q;
   logic             faultMask_d;
   logic [APB_DW-1:0] rdata_q;
   logic [APB_DW-1:0] rdata_d;

   // pin sampling
   logic [NPIN-1:0]  sync1_q;
   logic [NPIN-1:0]  sync2_q;
   logic [NPIN-1:0]  sync3_q;
   logic [NPIN-1:0]  pinLvl_q;
   logic [NPIN-1:0]  pinLvl_d;

   // pin drives
   pinDrive_t        ssDrv_q;
   pinDrive_t        ssDrv_d;
   pinDrive_t        moDrv_q;
   pinDrive_t        moDrv_d;
   pinDrive_t        miDrv_q;
   pinDrive_t        miDrv_d;
   logic             rxBit_q;
   logic             rxBit_d;

   ssRole_t          ssRole;

   // apb decode; zero wait states, one word per register
   // pready is tied high, so every access phase ends at its first edge
   wire logic setupPh  = psel && !penable;
   wire logic accessPh = psel && penable;
   wire logic hitCtl2  = paddr == CTL2_OFF;
   wire logic hitBaud  = paddr == BAUD_OFF;
   wire logic hitCfg   = paddr == CFG_OFF;
   wire logic hitStat  = paddr == STAT_OFF;
   wire logic hitMask  = paddr == MASK_OFF;
   wire logic hitAny   = hitCtl2 || hitBaud || hitCfg || hitStat || hitMask;
   // only byte lane 0 holds register bits
   wire logic wrLane0  = accessPh && pwrite && hitAny && pstrb[0];
   wire logic [REG_W-1:0] wByte = pwdata[REG_W-1:0];

   // register images as read back; unimplemented bits read zero
   wire logic [REG_W-1:0] ctl2Img = {
      3'b000,
      ctl2_q.faultDetectEnable,
      ctl2_q.singleWireOutputEnable,
      1'b0,
      ctl2_q.waitClockStop,
      ctl2_q.singleWireSelect
   }; // [RULE1]
   wire logic [REG_W-1:0] baudImg = {
      1'b0, baud_q.prescaleCode, 1'b0, baud_q.rateDivideCode
   };
   wire logic [REG_W-1:0] cfgImg  = {6'b00_0000, select_output_enable_q, master_q};
   wire logic [REG_W-1:0] statImg = {7'b000_0000, faultStat_q};
   wire logic [REG_W-1:0] maskImg = {7'b000_0000, faultMask_q};

   wire logic [REG_W-1:0] rdByte =
      hitCtl2 ? ctl2Img :
      hitBaud ? baudImg :
      hitCfg  ? cfgImg  :
      hitStat ? statImg :
      hitMask ? maskImg : BYTE_ZERO;

   // select pin role from mode and fault enable
   // slave role comes first: there the fault enable means nothing
   wire logic fdeEff = master_q && ctl2_q.faultDetectEnable; // [RULE2]
   always_comb begin
      if (!master_q) begin
         ssRole = SS_SLAVE_IN; // [RULE2]
      end else if (!ctl2_q.faultDetectEnable) begin
         ssRole = SS_PORT; // [RULE3]
      end else if (!select_output_enable_q) begin
         ssRole = SS_FAULT_IN; // [RULE4] [RULE5]
      end else begin
         ssRole = SS_AUTO_OUT; // [RULE4] [RULE5]
      end
   end

   wire logic ssLow      = !pinLvl_q[PIN_SS];
   // level-sensitive: a held-low input keeps re-setting the flag
   wire logic faultEvent = (ssRole == SS_FAULT_IN) && ssLow; // [RULE6]
   wire logic singleWire = ctl2_q.singleWireSelect;
   // output enable only counts in single-wire mode
   wire logic swDrive    = singleWire && ctl2_q.singleWireOutputEnable;
   // [RULE11]

   // clocks stop only when wait-stop is set and wait mode is entered
   wire logic runClocks  = !(ctl2_q.waitClockStop && waitMode); // [RULE12]

   // register next state
   // bus writes first, hardware events last, so a set beats a clear
   always_comb begin
      ctl2_d      = ctl2_q;
      baud_d      = baud_q;
      master_d    = master_q;
      select_output_enable_d      = select_output_enable_q;
      faultMask_d = faultMask_q;
      faultStat_d = faultStat_q;
      if (wrLane0 && hitCtl2) begin
         // positions 7,6,5,2 have no storage
         ctl2_d.faultDetectEnable      = wByte[CTL2_FDE_BIT]; // [RULE1]
         ctl2_d.singleWireOutputEnable = wByte[CTL2_SWOE_BIT];
         ctl2_d.waitClockStop          = wByte[CTL2_WCS_BIT];
         ctl2_d.singleWireSelect       = wByte[CTL2_SWS_BIT];
      end
      if (wrLane0 && hitBaud) begin
         // no transfer interlock; the generator copes with new codes
         baud_d.prescaleCode   =
            wByte[BAUD_PRE_LSB +: CODE_W]; // [RULE13] [RULE15]
         baud_d.rateDivideCode =
            wByte[BAUD_RATE_LSB +: CODE_W]; // [RULE13] [RULE16]
      end
      if (wrLane0 && hitCfg) begin
         master_d = wByte[CFG_MASTER_BIT];
         select_output_enable_d   = wByte[CFG_SELECT_OUTPUT_ENABLE_BIT];
      end
      if (wrLane0 && hitMask) begin
         faultMask_d = wByte[STAT_MODE_FAULT_FLAG_BIT];
      end
      if (wrLane0 && hitStat && wByte[STAT_MODE_FAULT_FLAG_BIT]) begin
         faultStat_d = 1'b0;
      end
      // a fault in the clearing cycle is kept
      if (faultEvent) begin
         faultStat_d = 1'b1; // [RULE6]
      end
   end

   // read data captured in the setup phase, shown in the access phase
   assign rdata_d = setupPh ? {{(APB_DW-REG_W){1'b0}}, rdByte} : rdata_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctl2_q      <= '{
            faultDetectEnable:      CTL2_RST[CTL2_FDE_BIT],
            singleWireOutputEnable: CTL2_RST[CTL2_SWOE_BIT],
            waitClockStop:          CTL2_RST[CTL2_WCS_BIT],
            singleWireSelect:       CTL2_RST[CTL2_SWS_BIT]
         }; // [RULE18]
         baud_q      <= '{
            prescaleCode:   BAUD_RST[BAUD_PRE_LSB +: CODE_W],
            rateDivideCode: BAUD_RST[BAUD_RATE_LSB +: CODE_W]
         }; // [RULE18]
         master_q    <= CFG_RST[CFG_MASTER_BIT];
         select_output_enable_q      <= CFG_RST[CFG_SELECT_OUTPUT_ENABLE_BIT];
         faultStat_q <= 1'b0;
         faultMask_q <= 1'b0;
         rdata_q     <= WORD_ZERO;
      end else begin
         ctl2_q      <= ctl2_d;
         baud_q      <= baud_d;
         master_q    <= master_d;
         select_output_enable_q      <= select_output_enable_d;
         faultStat_q <= faultStat_d;
         faultMask_q <= faultMask_d;
         rdata_q     <= rdata_d;
      end
   end

   // three-stage pin sampling; a change counts once stages 2 and 3 agree
   // select idles high so the reset value cannot fake a fault
   // filtered levels lag the pins by four edges
   wire logic [NPIN-1:0] stagesAgree = ~(sync2_q ^ sync3_q);
   assign pinLvl_d = (sync3_q  &  stagesAgree) |
                     (pinLvl_q & ~stagesAgree);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sync1_q  <= '1;
         sync2_q  <= '1;
         sync3_q  <= '1;
         pinLvl_q <= '1;
      end else begin
         sync1_q  <= {misoIn, mosiIn, ssIn};
         sync2_q  <= sync1_q;
         sync3_q  <= sync2_q;
         pinLvl_q <= pinLvl_d;
      end
   end

   // data pin steering
   // drives are registered so an enable never glitches on a pin
   always_comb begin
      moDrv_d = '{o: 1'b0, oe: 1'b0};
      miDrv_d = '{o: 1'b0, oe: 1'b0};
      rxBit_d = 1'b0;
      if (!singleWire) begin
         // two-wire: out on one pin, in on the other [RULE7]
         if (master_q) begin
            moDrv_d = '{o: shiftTxBit, oe: 1'b1};
            rxBit_d = pinLvl_q[PIN_MI];
         end else begin
            // slave drives its output only while selected
            miDrv_d = '{o: shiftTxBit, oe: ssLow};
            rxBit_d = pinLvl_q[PIN_MO];
         end
      end else if (master_q) begin
         // master-out pin shared; master-in left alone [RULE8] [RULE9]
         moDrv_d = '{o: shiftTxBit, oe: swDrive}; // [RULE10]
         rxBit_d = pinLvl_q[PIN_MO];
      end else begin
         // master-in pin shared in slave mode [RULE8]
         miDrv_d = '{o: shiftTxBit, oe: swDrive}; // [RULE10]
         rxBit_d = pinLvl_q[PIN_MI];
      end
   end

   // select pin drive: low while a transfer runs in auto mode [RULE5]
   // idles high so a released line agrees with the pull-up
   always_comb begin
      if (ssRole == SS_AUTO_OUT) begin
         ssDrv_d = '{o: !xferActive, oe: 1'b1};
      end else begin
         // input roles and port mode leave the driver off [RULE3]
         ssDrv_d = '{o: 1'b1, oe: 1'b0};
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ssDrv_q <= '{o: 1'b1, oe: 1'b0};
         moDrv_q <= '{o: 1'b0, oe: 1'b0};
         miDrv_q <= '{o: 1'b0, oe: 1'b0};
         rxBit_q <= 1'b0;
      end else begin
         ssDrv_q <= ssDrv_d;
         moDrv_q <= moDrv_d;
         miDrv_q <= miDrv_d;
         rxBit_q <= rxBit_d;
      end
   end

   // bit clock generator, run only as a master with clocks enabled
   // halting clears its counters, so a restart begins a fresh bit
   spi_baud_gen #(
      .CodeW (CODE_W),
      .HalfW (7)
   ) u_baud (
      .core_clk       (core_clk),
      .reset          (reset),
      .run            (runClocks && master_q), // [RULE12] [RULE16]
      .prescaleCode   (baud_q.prescaleCode),  // [RULE14]
      .rateDivideCode (baud_q.rateDivideCode),
      .edgeTick       (sckEdgeTick),
      .bitTick        (bitTick)
   );

   // outputs
   // handshake and status are combinational, pin drives registered
   assign prdata        = rdata_q;
   assign pready        = 1'b1;
   assign pslverr       = accessPh && !hitAny; // unmapped address
   assign irq           = faultStat_q && faultMask_q;
   assign modeFaultFlag = faultStat_q;
   assign clocksRun     = runClocks; // [RULE12]
   // slave select seen only in slave role [RULE2]
   assign slaveSelected = !master_q && ssLow;
   assign ssPortFree    = (ssRole == SS_PORT) && !fdeEff; // [RULE3]
   assign misoPortFree  = master_q && singleWire; // [RULE9]
   assign shiftRxBit    = rxBit_q;
   assign ssOut         = ssDrv_q.o;
   assign select_output_enable          = ssDrv_q.oe;
   assign mosiOut       = moDrv_q.o;
   assign mosiOe        = moDrv_q.oe;
   assign misoOut       = miDrv_q.o;
   assign misoOe        = miDrv_q.oe;

endmodule : spi_pin_control

// ===== spi_pin_control_and_baud_gen_test.sv
module spi_pin_control_and_baud_gen_test
   import spi_pins_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              core_clk = 1'b0;
   logic              reset = 1'b1;
   logic [APB_AW-1:0] paddr = '0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [APB_DW-1:0] pwdata = '0;
   logic [3:0]        pstrb = 4'h1;
   logic [APB_DW-1:0] prdata;
   logic              pready, pslverr, irq, lastErr;
   logic              waitMode = 1'b0;
   logic              xferActive = 1'b0;
   logic              shiftTxBit = 1'b0;
   logic              shiftRxBit, clocksRun, sckEdgeTick, bitTick;
   logic              modeFaultFlag, slaveSelected, ssPortFree;
   logic              misoPortFree, ssIn, ssOut, select_output_enable, mosiIn, mosiOut;
   logic              mosiOe, misoIn, misoOut, misoOe;
   logic              ssLow = 1'b0;
   logic              drvMosi = 1'b0;
   logic              drvMiso = 1'b0;
   int                badCount = 0;
   int                nCompared = 0;
   int                cycles = 0;

   spi_pin_control i_spi_pin_control (.core_clk, .reset, .paddr, .psel,
      .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq,
      .waitMode, .xferActive, .shiftTxBit, .shiftRxBit, .clocksRun,
      .sckEdgeTick, .bitTick, .modeFaultFlag, .slaveSelected, .ssPortFree,
      .misoPortFree, .ssIn, .ssOut, .select_output_enable, .mosiIn, .mosiOut, .mosiOe,
      .misoIn, .misoOut, .misoOe);
   spi_far_peer i_spi_far_peer (.ssOut, .select_output_enable, .mosiOut, .mosiOe, .misoOut,
      .misoOe, .ssLow, .drvMosi, .drvMiso, .ssIn, .mosiIn, .misoIn);

   always #5 core_clk = !core_clk;

   // hang guard, well above the longest baud sweep
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         badCount++;
         results();
      end
   end

   task automatic results;
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   task automatic check(input string w, input logic [31:0] s, e);
      nCompared++;
      if (s !== e) begin
         badCount++;
         $display("unexpected %s: expected %h seen %h", w, e, s);
      end
   endtask : check

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_cycles

   // one apb transfer; idle cycle after so psel is never set twice at once
   task automatic xfer(input logic [APB_AW-1:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // ends once pready is seen high; only the bench timeout ends a wait that never sees it
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      r = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : xfer

   task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask : wr

   task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] e,
                     input string w);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h0000_0000, r);
      check(w, r, e);
   endtask : rd

   task automatic t_regs;
      rd(CTL2_OFF, 32'h0000_0000, "control two reset");
      rd(BAUD_OFF, 32'h0000_0000, "baud reset");
      wr(CTL2_OFF, 32'h0000_00FF);
      rd(CTL2_OFF, 32'h0000_001B, "control two unused");
      wr(BAUD_OFF, 32'h0000_00FF);
      rd(BAUD_OFF, 32'h0000_0077, "baud fields");
      rd(12'h020, 32'h0000_0000, "unmapped data");
      check("unmapped error", 32'(lastErr), 32'h0000_0001);
      wr(CTL2_OFF, 32'h0000_0000);
      $display("test regs done");
   endtask : t_regs

   task automatic wait_tick;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (bitTick !== 1'b1 && n < 3000);
   endtask : wait_tick

   // codes are changed while the generator runs
   task automatic rate(input int p, input int r);
      int n;
      int e;
      wr(BAUD_OFF, 32'((p << 4) | r));
      wait_tick();
      wait_tick();
      n = 0;
      e = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (sckEdgeTick === 1'b1) e++;
      end while (bitTick !== 1'b1 && n < 3000);
      check("bit period", 32'(n), 32'((p + 1) << (r + 1)));
      check("half ticks", 32'(e), 32'h0000_0002);
   endtask : rate

   task automatic t_baud;
      wr(CFG_OFF, 32'h0000_0001);
      for (int i = 0; i < 8; i++) begin
         rate(i, 0);
         rate(0, i);
      end
      rate(7, 7);
      $display("test baud done");
   endtask : t_baud

   task automatic t_wait;
      int n;
      n = 0;
      wr(CTL2_OFF, 32'h0000_0002);
      waitMode <= 1'b1;
      wait_cycles(4);
      check("clocks held", 32'(clocksRun), 32'h0000_0000);
      repeat (600) begin
         @(posedge core_clk);
         if (bitTick !== 1'b0) n++;
      end
      check("ticks held", 32'(n), 32'h0000_0000);
      wr(CTL2_OFF, 32'h0000_0000);
      check("clocks in wait", 32'(clocksRun), 32'h0000_0001);
      waitMode <= 1'b0;
      $display("test wait done");
   endtask : t_wait

   task automatic t_select;
      wr(CTL2_OFF, 32'h0000_0010);
      ssLow <= 1'b1;
      wait_cycles(8);
      check("fault flag", 32'(modeFaultFlag), 32'h0000_0001);
      check("irq masked", 32'(irq), 32'h0000_0000);
      wr(MASK_OFF, 32'h0000_0001);
      check("irq raised", 32'(irq), 32'h0000_0001);
      ssLow <= 1'b0;
      wait_cycles(8);
      wr(STAT_OFF, 32'h0000_0001);
      check("fault cleared", 32'({modeFaultFlag, irq}), 32'h0000_0000);
      wr(CFG_OFF, 32'h0000_0003);
      xferActive <= 1'b1;
      wait_cycles(3);
      check("auto select", 32'({select_output_enable, ssOut}), 32'h0000_0002);
      xferActive <= 1'b0;
      wait_cycles(3);
      check("auto idle", 32'({select_output_enable, ssOut}), 32'h0000_0003);
      wr(CTL2_OFF, 32'h0000_0000);
      ssLow <= 1'b1;
      wait_cycles(8);
      check("select free", 32'({ssPortFree, select_output_enable, modeFaultFlag}), 32'h0000_0004);
      wr(CFG_OFF, 32'h0000_0000);
      wr(CTL2_OFF, 32'h0000_0010);
      wait_cycles(2);
      check("slave select", 32'({slaveSelected, select_output_enable, modeFaultFlag}), 32'h0000_0004);
      ssLow <= 1'b0;
      wait_cycles(8);
      $display("test select done");
   endtask : t_select

   // pin: 0 none, 1 peer pulls master-in low, 2 peer pulls master-out low
   task automatic mode(input logic [31:0] c, t, input logic [2:0] e,
                       input logic [1:0] pin, input string w);
      wr(CFG_OFF, c);
      wr(CTL2_OFF, t);
      drvMiso <= (pin == 2'd1);
      drvMosi <= (pin == 2'd2);
      wait_cycles(8);
      check(w, 32'({mosiOe, misoOe, misoPortFree}), 32'(e));
      check(w, 32'({mosiOut, misoOut}), 32'({c[0], !c[0]}));
      if (pin != 2'd0) check(w, 32'(shiftRxBit), 32'h0000_0000);
      drvMiso <= 1'b0;
      drvMosi <= 1'b0;
      wait_cycles(1);
   endtask : mode

   task automatic t_data;
      // driven pins read high, pulled pins low: a wrong rx pin shows
      shiftTxBit <= 1'b1;
      wr(BAUD_OFF, 32'h0000_0000);
      mode(32'h0000_0001, 32'h0000_0000, 3'b100, 2'd1, "two wire");
      mode(32'h0000_0001, 32'h0000_0008, 3'b100, 2'd1, "oe ignored");
      mode(32'h0000_0001, 32'h0000_0001, 3'b001, 2'd2, "one wire rx");
      mode(32'h0000_0001, 32'h0000_0009, 3'b101, 2'd0, "one wire tx");
      mode(32'h0000_0000, 32'h0000_0009, 3'b010, 2'd0, "slave one wire");
      $display("test data done");
   endtask : t_data

   initial begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      t_regs();
      t_baud();
      t_wait();
      t_select();
      t_data();
      results();
   end
endmodule : spi_pin_control_and_baud_gen_test

bind spi_pin_control spi_pin_chk i_spi_pin_chk (.core_clk, .reset, .irq,
   .modeFaultFlag, .ssPortFree, .slaveSelected, .misoPortFree, .ssOut, .select_output_enable,
   .xferActive, .mosiOe, .misoOe, .waitMode, .clocksRun, .sckEdgeTick,
   .bitTick);

// ===== spi_pins_pkg.sv
package spi_pins_pkg;

   // bus geometry
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   localparam int REG_W  = 8;

   // register byte offsets
   localparam logic [APB_AW-1:0] CTL2_OFF = 12'h000;
   localparam logic [APB_AW-1:0] BAUD_OFF = 12'h004;
   localparam logic [APB_AW-1:0] CFG_OFF  = 12'h008;
   localparam logic [APB_AW-1:0] STAT_OFF = 12'h00C;
   localparam logic [APB_AW-1:0] MASK_OFF = 12'h010;

   // control-two field positions
   localparam int CTL2_FDE_BIT  = 4;
   localparam int CTL2_SWOE_BIT = 3;
   localparam int CTL2_WCS_BIT  = 1;
   localparam int CTL2_SWS_BIT  = 0;

   // baud-select field positions
   localparam int CODE_W        = 3;
   localparam int BAUD_PRE_LSB  = 4;
   localparam int BAUD_RATE_LSB = 0;

   // configuration and event field positions
   localparam int CFG_MASTER_BIT = 0;
   localparam int CFG_SELECT_OUTPUT_ENABLE_BIT   = 1;
   localparam int STAT_MODE_FAULT_FLAG_BIT  = 0;

   // reset values
   localparam logic [REG_W-1:0] CTL2_RST = 8'h00;
   localparam logic [REG_W-1:0] BAUD_RST = 8'h00;
   localparam logic [REG_W-1:0] CFG_RST  = 8'h00;
   localparam logic [REG_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [APB_DW-1:0] WORD_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic faultDetectEnable;
      logic singleWireOutputEnable;
      logic waitClockStop;
      logic singleWireSelect;
   } ctl2_t;

   typedef struct packed {
      logic [CODE_W-1:0] prescaleCode;
      logic [CODE_W-1:0] rateDivideCode;
   } baud_t;

   typedef struct packed {
      logic o;
      logic oe;
   } pinDrive_t;

   typedef enum {
      SS_SLAVE_IN,
      SS_PORT,
      SS_FAULT_IN,
      SS_AUTO_OUT
   } ssRole_t;

endpackage : spi_pins_pkg
